/* File: src/fpr_pkg.sv */
// Constants shared by the fan range and frequency configuration block
package fpr_pkg;

    localparam int NUM_CH    = 3;
    localparam int CLK_HZ    = 10_000_000;
    localparam int TEMP_W    = 10;
    localparam int LIMIT_W   = 8;
    localparam int DUTY_W    = 8;
    localparam int SPAN_CW   = 14;
    localparam int DIV_W     = 12;

    // Register offsets, one per channel
    localparam logic [7:0] ADDR_CH [NUM_CH] = '{8'h5F, 8'h60, 8'h61};
    localparam logic [7:0] CFG_RESET        = 8'hC4;
    localparam logic [7:0] RD_UNMAPPED      = 8'h00;

    // Field layout
    localparam int RATE_LSB  = 0;
    localparam int RATE_W    = 3;
    localparam int ALARM_BIT = 3;
    localparam int SPAN_LSB  = 4;
    localparam int SPAN_W    = 4;

    // One PWM period is this many reference ticks
    localparam int PWM_STEPS = 256;

    // Output frequency per rate code, in tenths of a hertz
    localparam int RATE_DHZ [8] = '{110, 147, 221, 294,
                                    353, 441, 588, 882};

    function automatic int step_cycles(input int dhz);
        return (CLK_HZ * 10) / (dhz * PWM_STEPS);
    endfunction

    // Clock cycles per reference tick, per rate code
    localparam int STEP_CYC [8] = '{
        step_cycles(RATE_DHZ[0]), step_cycles(RATE_DHZ[1]),
        step_cycles(RATE_DHZ[2]), step_cycles(RATE_DHZ[3]),
        step_cycles(RATE_DHZ[4]), step_cycles(RATE_DHZ[5]),
        step_cycles(RATE_DHZ[6]), step_cycles(RATE_DHZ[7])};

    // Ramp span per span code, in hundredths of a degree
    localparam logic [SPAN_CW-1:0] SPAN_CENTI [16] = '{
        14'd200,  14'd250,  14'd333,  14'd400,
        14'd500,  14'd667,  14'd800,  14'd1000,
        14'd1333, 14'd1600, 14'd2000, 14'd2667,
        14'd3200, 14'd4000, 14'd5333, 14'd8000};

endpackage

/* File: src/fpr_alarm_chan.sv */
// Per-channel thermal alarm tracker
`timescale 1ns/10ps
module fpr_alarm_chan
    import fpr_pkg::*;
(
    input  wire logic               sys_clk,
    input  wire logic               resetn,
    input  wire logic               clk_en,
    input  wire logic               alarm_enable,
    input  wire logic               monitor_done,
    input  wire logic [TEMP_W-1:0]  temp_qdeg,
    input  wire logic [LIMIT_W-1:0] limit_deg,
    output logic                    alarm_q
);

    logic over_limit;

    // Temperature is in quarter degrees, limit in whole degrees
    assign over_limit = temp_qdeg > {limit_deg, 2'b00};

    // Decided at measurement ends, so one cycle is the least hold; clearing alarm_enable drops it at once
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            alarm_q <= 1'b0;
        end else if (clk_en) begin
            if (!alarm_enable) begin
                alarm_q <= 1'b0;
            end else if (monitor_done) begin
                if (!alarm_q && over_limit) begin
                    alarm_q <= 1'b1;
                end else if (alarm_q && !over_limit) begin
                    alarm_q <= 1'b0;
                end
            end
        end
    end

endmodule

/* File: src/fpr_range_pwm_rate_select.sv */
// Range and frequency configuration with PWM drive and alarm pin
`timescale 1ns/10ps
module fpr_range_pwm_rate_select
    import fpr_pkg::*;
(
    input  wire logic               sys_clk,
    input  wire logic               resetn,
    input  wire logic               clk_en,
    // Register port
    input  wire logic [7:0]         reg_addr,
    input  wire logic [7:0]         reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic [7:0]              reg_rdata_q,
    // Global lock from the configuration register
    input  wire logic               config_lock,
    // Measurements, one strobe per monitoring cycle
    input  wire logic               monitor_done,
    input  wire logic [TEMP_W-1:0]  temp_remote1,
    input  wire logic [TEMP_W-1:0]  temp_local,
    input  wire logic [TEMP_W-1:0]  temp_remote2,
    input  wire logic [LIMIT_W-1:0] limit_remote1,
    input  wire logic [LIMIT_W-1:0] limit_local,
    input  wire logic [LIMIT_W-1:0] limit_remote2,
    // Duty from the automatic control
    input  wire logic [DUTY_W-1:0]  duty_one,
    input  wire logic [DUTY_W-1:0]  duty_two,
    input  wire logic [DUTY_W-1:0]  duty_three,
    // Fan drive outputs
    output logic                    fan_drive_one_q,
    output logic                    fan_drive_two_q,
    output logic                    fan_drive_three_q,
    // Ramp span per channel, hundredths of a degree
    output logic [SPAN_CW-1:0]      span_remote1_q,
    output logic [SPAN_CW-1:0]      span_local_q,
    output logic [SPAN_CW-1:0]      span_remote2_q,
    // Open-drain alarm pin, active low
    input  wire logic               thermal_alarm_pin_n_in,
    output logic                    thermal_alarm_pin_n_out_q,
    output logic                    thermal_alarm_pin_oe_q,
    output logic                    processor_hot_signal_q
);

    logic [7:0]         cfg_q       [NUM_CH];
    logic [TEMP_W-1:0]  temp_ch     [NUM_CH];
    logic [LIMIT_W-1:0] limit_ch    [NUM_CH];
    logic [DUTY_W-1:0]  duty_ch     [NUM_CH];
    logic [NUM_CH-1:0]  pwm_q;
    logic [SPAN_CW-1:0] span_q      [NUM_CH];
    logic [NUM_CH-1:0]  alarm_q;
    logic [NUM_CH-1:0]  alarm_en;
    logic [7:0]         rdata_d;
    logic               pin_s1_q;
    logic               pin_s2_q;
    logic               drive_d;

    typedef enum logic [1:0] {
        PIN_FREE,
        PIN_PULL,
        PIN_SETTLE1,
        PIN_SETTLE2
    } fpr_pin_e;

    fpr_pin_e           pin_st_q;
    fpr_pin_e           pin_st_d;

    // Channel order follows the register offsets
    assign temp_ch[0]  = temp_remote1;
    assign temp_ch[1]  = temp_local;
    assign temp_ch[2]  = temp_remote2;
    assign limit_ch[0] = limit_remote1;
    assign limit_ch[1] = limit_local;
    assign limit_ch[2] = limit_remote2;
    assign duty_ch[0]  = duty_one;
    assign duty_ch[1]  = duty_two;
    assign duty_ch[2]  = duty_three;

    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
            logic [DIV_W-1:0]  pre_q;
            logic [7:0]        step_q;
            logic [RATE_W-1:0] rate_act_q;
            logic [DIV_W-1:0]  div_last;
            logic              tick;
            logic              wr_hit;

            assign wr_hit = reg_wr && (reg_addr == ADDR_CH[ch]);
            assign alarm_en[ch] = cfg_q[ch][ALARM_BIT];

            // Configuration register
            always_ff @(posedge sys_clk) begin
                if (!resetn) begin
                    cfg_q[ch] <= CFG_RESET;
                end else if (clk_en) begin
                    if (wr_hit && !config_lock) begin
                        cfg_q[ch] <= reg_wdata;
                    end
                end
            end

            // Reference tick: clock divided by the active rate code
            assign div_last = DIV_W'(STEP_CYC[rate_act_q] - 1);
            assign tick     = (pre_q == div_last);

            always_ff @(posedge sys_clk) begin
                if (!resetn) begin
                    pre_q <= '0;
                end else if (clk_en) begin
                    if (tick) begin
                        pre_q <= '0;
                    end else begin
                        pre_q <= pre_q + 1'b1;
                    end
                end
            end

            // Period position, one step per reference tick
            always_ff @(posedge sys_clk) begin
                if (!resetn) begin
                    step_q <= '0;
                end else if (clk_en) begin
                    if (tick) begin
                        step_q <= step_q + 1'b1;
                    end
                end
            end

            // New rate only at the period boundary, avoiding runt pulses
            always_ff @(posedge sys_clk) begin
                if (!resetn) begin
                    rate_act_q <= CFG_RESET[RATE_LSB +: RATE_W];
                end else if (clk_en) begin
                    if (tick && (step_q == 8'hFF)) begin
                        rate_act_q <= cfg_q[ch][RATE_LSB +: RATE_W];
                    end
                end
            end

            // High for the first duty steps of each period
            always_ff @(posedge sys_clk) begin
                if (!resetn) begin
                    pwm_q[ch] <= 1'b0;
                end else if (clk_en) begin
                    pwm_q[ch] <= (step_q < duty_ch[ch]);
                end
            end

            // Span decode for the automatic duty ramp
            always_ff @(posedge sys_clk) begin
                if (!resetn) begin
                    span_q[ch] <= SPAN_CENTI[CFG_RESET[SPAN_LSB +: SPAN_W]];
                end else if (clk_en) begin
                    span_q[ch] <= SPAN_CENTI[cfg_q[ch][SPAN_LSB +: SPAN_W]];
                end
            end

            fpr_alarm_chan u_alarm (
                .sys_clk      (sys_clk),
                .resetn       (resetn),
                .clk_en       (clk_en),
                .alarm_enable (alarm_en[ch]),
                .monitor_done (monitor_done),
                .temp_qdeg    (temp_ch[ch]),
                .limit_deg    (limit_ch[ch]),
                .alarm_q      (alarm_q[ch])
            );
        end
    endgenerate

    assign fan_drive_one_q   = pwm_q[0];
    assign fan_drive_two_q   = pwm_q[1];
    assign fan_drive_three_q = pwm_q[2];
    assign span_remote1_q    = span_q[0];
    assign span_local_q      = span_q[1];
    assign span_remote2_q    = span_q[2];

    // Read mux; unmapped offsets read zero
    always_comb begin
        rdata_d = RD_UNMAPPED;
        for (int i = 0; i < NUM_CH; i++) begin
            if (reg_addr == ADDR_CH[i]) begin
                rdata_d = cfg_q[i];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            reg_rdata_q <= RD_UNMAPPED;
        end else if (clk_en) begin
            if (reg_rd) begin
                reg_rdata_q <= rdata_d;
            end else begin
                reg_rdata_q <= RD_UNMAPPED;
            end
        end
    end

    // Only enabled channels may pull the pin
    assign drive_d = |(alarm_q & alarm_en);

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            thermal_alarm_pin_oe_q <= 1'b0;
        end else if (clk_en) begin
            thermal_alarm_pin_oe_q <= drive_d;
        end
    end

    // Open drain: the driven level is always low
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            thermal_alarm_pin_n_out_q <= 1'b0;
        end else if (clk_en) begin
            thermal_alarm_pin_n_out_q <= 1'b0;
        end
    end

    // Pin synchroniser
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            pin_s1_q <= 1'b1;
            pin_s2_q <= 1'b1;
        end else if (clk_en) begin
            pin_s1_q <= thermal_alarm_pin_n_in;
            pin_s2_q <= pin_s1_q;
        end
    end

    // Own release reaches the synchroniser two clocks late; mask it
    always_comb begin
        pin_st_d = pin_st_q;
        case (pin_st_q)
            PIN_FREE: begin
                if (drive_d) begin
                    pin_st_d = PIN_PULL;
                end
            end
            PIN_PULL: begin
                if (!drive_d) begin
                    pin_st_d = PIN_SETTLE1;
                end
            end
            PIN_SETTLE1: begin
                pin_st_d = drive_d ? PIN_PULL : PIN_SETTLE2;
            end
            PIN_SETTLE2: begin
                pin_st_d = drive_d ? PIN_PULL : PIN_FREE;
            end
            default: begin
                pin_st_d = PIN_FREE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            pin_st_q <= PIN_FREE;
        end else if (clk_en) begin
            pin_st_q <= pin_st_d;
        end
    end

    // Pin low from outside while not driving it ourselves
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            processor_hot_signal_q <= 1'b0;
        end else if (clk_en) begin
            processor_hot_signal_q <= !pin_s2_q && (pin_st_q == PIN_FREE);
        end
    end

endmodule

/* File: dv/fpr_pin_model.sv */
// Open-drain alarm pin with pull-up and an outside party
`timescale 1ns/10ps
module fpr_pin_model (
    input  wire logic oe,
    input  wire logic out_n,
    input  wire logic ext_low,
    output logic      pin_n
);
    // Pull-up wins unless someone sinks the line
    assign pin_n = ((oe && !out_n) || ext_low) ? 1'b0 : 1'b1;
endmodule

/* File: dv/fpr_sva.sv */
// Port-level assertions for the range and frequency block
`timescale 1ns/10ps
module fpr_sva
    import fpr_pkg::*;
(
    input wire logic               sys_clk,
    input wire logic               resetn,
    input wire logic               clk_en,
    input wire logic [7:0]         reg_addr,
    input wire logic [7:0]         reg_wdata,
    input wire logic               reg_wr,
    input wire logic               reg_rd,
    input wire logic [7:0]         reg_rdata_q,
    input wire logic               config_lock,
    input wire logic               monitor_done,
    input wire logic [DUTY_W-1:0]  duty_one,
    input wire logic               fan_drive_one_q,
    input wire logic [SPAN_CW-1:0] span_local_q,
    input wire logic               thermal_alarm_pin_n_in,
    input wire logic               thermal_alarm_pin_n_out_q,
    input wire logic               thermal_alarm_pin_oe_q,
    input wire logic               processor_hot_signal_q
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn || !clk_en);
    rd_idle_a: assert property (
        (!reg_rd || reg_addr < 8'h5F || reg_addr > 8'h61)
        |=> reg_rdata_q == 8'h00) else $error("stray read data");
    wr_rd_a: assert property (
        (reg_wr && !config_lock && reg_addr == 8'h60) ##1
        (reg_rd && reg_addr == 8'h60)
        |=> reg_rdata_q == $past(reg_wdata, 2))
        else $error("readback differs");
    lock_span_a: assert property (
        (reg_wr && config_lock) |=> ##1 $stable(span_local_q))
        else $error("locked write changed span");
    span_reset_a: assert property (
        $rose(resetn) |-> span_local_q == 14'd3200)
        else $error("span reset value wrong");
    oe_level_a: assert property (
        thermal_alarm_pin_oe_q |-> !thermal_alarm_pin_n_out_q)
        else $error("pin driven high");
    oe_cause_a: assert property (
        $rose(thermal_alarm_pin_oe_q) |-> $past(monitor_done, 2))
        else $error("alarm without strobe");
    hot_cause_a: assert property (
        $rose(processor_hot_signal_q)
        |-> $past(thermal_alarm_pin_n_in, 3) == 1'b0)
        else $error("hot flag without low pin");
    hot_release_a: assert property (
        $fell(thermal_alarm_pin_oe_q) |-> !processor_hot_signal_q [*3])
        else $error("hot flag after own release");
    fan_zero_a: assert property (
        duty_one == 8'h00 |=> !fan_drive_one_q)
        else $error("fan high at zero duty");
endmodule
bind fpr_range_pwm_rate_select fpr_sva u_sva (.sys_clk, .resetn, .clk_en, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q, .config_lock,
    .monitor_done, .duty_one, .fan_drive_one_q, .span_local_q,
    .thermal_alarm_pin_n_in, .thermal_alarm_pin_n_out_q,
    .thermal_alarm_pin_oe_q, .processor_hot_signal_q);

/* File: dv/tb_top.sv */
// Self-checking bench for the range and frequency block
`timescale 1ns/10ps
module tb_top
    import fpr_pkg::*;
;
    logic sys_clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0;
    logic config_lock = 0, monitor_done = 0, ext_low = 0, pin_n;
    logic clk_en = 1;
    logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata_q;
    logic [9:0] temp_remote1 = 10'd40, temp_local = 10'd40;
    logic [9:0] temp_remote2 = 10'd40;
    logic [7:0] limit_remote1 = 8'hFF, limit_local = 8'd50;
    logic [7:0] limit_remote2 = 8'hFF;
    logic [7:0] duty_one = 8'h01, duty_two = 8'h00, duty_three = 8'hFF;
    logic fan_drive_one_q, fan_drive_two_q, fan_drive_three_q;
    logic [13:0] span_remote1_q, span_local_q, span_remote2_q;
    logic thermal_alarm_pin_n_out_q, thermal_alarm_pin_oe_q;
    logic processor_hot_signal_q;
    logic [15:0] lf = 16'hA50E;
    logic [7:0] last [3];
    int err_total = 0, samples_checked = 0, n;
    fpr_range_pwm_rate_select uut (.sys_clk, .resetn, .clk_en, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q, .config_lock,
        .monitor_done, .temp_remote1, .temp_local, .temp_remote2,
        .limit_remote1, .limit_local, .limit_remote2, .duty_one,
        .duty_two, .duty_three, .fan_drive_one_q, .fan_drive_two_q,
        .fan_drive_three_q, .span_remote1_q, .span_local_q,
        .span_remote2_q, .thermal_alarm_pin_n_in(pin_n),
        .thermal_alarm_pin_n_out_q, .thermal_alarm_pin_oe_q,
        .processor_hot_signal_q);
    fpr_pin_model u_pin (.oe(thermal_alarm_pin_oe_q),
        .out_n(thermal_alarm_pin_n_out_q), .ext_low, .pin_n);
    initial begin
        forever #50 sys_clk = ~sys_clk;
    end
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    function automatic logic [13:0] span_exp(input logic [3:0] c);
        int t [16] = '{200, 250, 333, 400, 500, 667, 800, 1000, 1333,
                       1600, 2000, 2667, 3200, 4000, 5333, 8000};
        return t[c][13:0];
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk) reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk) reg_rd <= 1'b0;
        #1 chk(reg_rdata_q, exp);
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask
    task automatic pulse();
        monitor_done <= 1'b1;
        @(posedge sys_clk) monitor_done <= 1'b0;
        #1;
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk);
        err_total++;
        complete_run();
    end
    initial begin
        repeat (16) @(posedge sys_clk);
        resetn <= 1'b1;
        tick(1);
        for (n = 0; n < 20 && fan_drive_one_q !== 1'b1; n++) tick(1);
        chk({fan_drive_two_q, fan_drive_three_q}, 2'b01);
        for (n = 0; n < 5000 && fan_drive_one_q === 1'b1; n++) tick(1);
        chk(n, 100_000_000 / (353 * 256));
        for (int i = 0; i < 3; i++) rd(ADDR_CH[i], 8'hC4);
        chk(span_remote1_q, 14'd3200);
        chk(span_remote2_q, 14'd3200);
        rd(8'h5E, 8'h00);
        rd(8'h62, 8'h00);
        for (int i = 0; i < 16; i++) begin
            wr(8'h60, {i[3:0], 4'h4});
            tick(1);
            chk(span_local_q, span_exp(i[3:0]));
        end
        for (int k = 0; k < 12; k++) begin
            lf = lfsr(lf);
            last[k % 3] = lf[7:0] & 8'hF7;
            wr(ADDR_CH[k % 3], last[k % 3]);
            rd(ADDR_CH[k % 3], last[k % 3]);
        end
        chk(span_remote1_q, span_exp(last[0][7:4]));
        chk(span_remote2_q, span_exp(last[2][7:4]));
        config_lock <= 1'b1;
        wr(8'h5F, ~last[0]);
        rd(8'h5F, last[0]);
        wr(8'h60, ~last[1]);
        rd(8'h60, last[1]);
        chk(span_local_q, span_exp(last[1][7:4]));
        config_lock <= 1'b0;
        temp_local <= 10'd201;
        wr(8'h60, 8'hCC);
        pulse();
        tick(1);
        chk({thermal_alarm_pin_oe_q, pin_n}, 2'b10);
        temp_local <= 10'd200;
        tick(3);
        chk(thermal_alarm_pin_oe_q, 1'b1);
        pulse();
        tick(1);
        chk({thermal_alarm_pin_oe_q, pin_n}, 2'b01);
        tick(1);
        chk(processor_hot_signal_q, 1'b0);
        wr(8'h60, 8'hC4);
        temp_local <= 10'd300;
        pulse();
        tick(2);
        chk(thermal_alarm_pin_oe_q, 1'b0);
        ext_low <= 1'b1;
        tick(4);
        chk(processor_hot_signal_q, 1'b1);
        ext_low <= 1'b0;
        tick(4);
        duty_one <= 8'hFF;
        tick(2);
        chk(fan_drive_one_q, 1'b1);
        duty_one <= 8'h00;
        tick(2);
        chk(fan_drive_one_q, 1'b0);
        clk_en <= 1'b0;
        wr(8'h60, 8'h35);
        tick(1);
        chk(span_local_q, 14'd3200);
        clk_en <= 1'b1;
        rd(8'h60, 8'hC4);
        complete_run();
    end
endmodule
